// ### design/tms_defines.svh
// constants for the two-wire mux slave port and aux pins
// assumes inclusion by bare name from design files
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH
`define TMS_ADDR_TOP      2'h2
`define TMS_BCAST_ADDR    7'h5d
`define TMS_ARA_ADDR      7'h0c
`define TMS_CLK_NS        5
`define TMS_GLITCH_NS     50
`define TMS_FILT_CYC      ((`TMS_GLITCH_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS + 1)
`define TMS_REG2_BCAST    7
`define TMS_REG2_DIR1     6
`define TMS_REG2_DIR2     5
`define TMS_REG2_OD1      4
`define TMS_REG2_OD2      3
`define TMS_REG1_DRV1     5
`define TMS_REG1_DRV2     4
`define TMS_REG1_SNS1     1
`define TMS_REG1_SNS2     0
`define TMS_REG2_RST      8'h80
`define TMS_REG1_RST      8'h30
`define TMS_STRAP_LO      2'h0
`define TMS_STRAP_HI      2'h1
`define TMS_STRAP_NC      2'h2
`endif

// ### design/tms_pkg.sv
// types for the two-wire mux slave port
// assumes tms_defines.svh for numeric constants
package tms_pkg;
    typedef logic [1:0] tms_strap_t;
    typedef enum logic [2:0] {
        TMS_IDLE  = 3'h0,
        TMS_ADDR  = 3'h1,
        TMS_CMD   = 3'h2,
        TMS_DATA  = 3'h3,
        TMS_RDATA = 3'h4,
        TMS_ACK   = 3'h5,
        TMS_RACK  = 3'h6,
        TMS_SKIP  = 3'h7
    } tms_state_e;
endpackage

// ### design/tms_filter.sv
// glitch filter with two-flop synchroniser for one upstream line
// assumes an asynchronous pin input and a single clk domain
`timescale 1ns/1ps
`include "tms_defines.svh"
module tms_filter #(
    parameter int FILT_CYC = `TMS_FILT_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);
    logic       sync_a;
    logic       sync_b;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_level;

    always_comb begin
        next_cnt   = 8'h00;
        next_level = level;
        if (sync_b != level) begin
            next_cnt = cnt + 8'h01;
            if (cnt >= 8'(FILT_CYC - 1)) begin
                next_level = sync_b;
                next_cnt   = 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            cnt    <= 8'h00;
            level  <= 1'b1;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            cnt    <= next_cnt;
            level  <= next_level;
        end
    end

    glitch_reject_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(level) |-> $past(sync_b, 1) == level && $past(sync_b, FILT_CYC) == level)
        else $error("filtered level changed without stable input");
endmodule

// ### design/tms_slave.sv
// What this block does
// - own seven-bit address comes from three tri-level straps, twenty-seven choices.
// - top two address bits fixed at one then zero.
// - straps map to address bits four to zero per fixed table.
// - broadcast write address accepted regardless of strap address.
// - broadcast write ignored when its enable bit in register two is zero.
// - alert response address recognised as a read.
// - repeated start before stop discards the pending write.
// - data byte committed to pointer-selected register only at stop.
// - per-pin direction bit in register two picks input or output.
// - per-pin open-drain bit in register two picks open-drain or push-pull output.
// - register one reports sensed level of each aux pin.
// - register one holds the level each aux pin is driven to.
// - pulses up to 50 ns on upstream lines are rejected.
// - alert response read handled besides ordinary byte read and write.
// - alert response read while alerting returns own address, releases alert.
// - addressing at own address also releases alert.
//
// two-wire slave command port with two aux pins
// assumes straps static, alert requests come from fault logic on clk
`timescale 1ns/1ps
`include "tms_defines.svh"
module tms_slave
    import tms_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire tms_pkg::tms_strap_t strap_addr_pin_lo,
    input  wire tms_pkg::tms_strap_t strap_addr_pin_mid,
    input  wire tms_pkg::tms_strap_t strap_addr_pin_hi,
    input  wire logic             upstream_clock_line,
    input  wire logic             upstream_data_line,
    output logic                  data_oe,
    input  wire logic             alert_set,
    output logic                  alert_active,
    input  wire logic             aux_pin_one_in,
    output logic                  aux_pin_one_out,
    output logic                  aux_pin_one_oe,
    input  wire logic             aux_pin_two_in,
    output logic                  aux_pin_two_out,
    output logic                  aux_pin_two_oe,
    output logic [7:0]            reg0_wdata,
    output logic                  reg0_wstrobe,
    output logic [7:0]            reg3_ctrl
);
    import tms_pkg::*;
    // ------------------------------------------------
    // filtering and edge detection
    // ------------------------------------------------
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    logic a1_s, a1_q, a2_s, a2_q;
    tms_filter u_fscl (.clk(clk), .sys_rst(sys_rst), .pin(upstream_clock_line), .level(scl));
    tms_filter u_fsda (.clk(clk), .sys_rst(sys_rst), .pin(upstream_data_line), .level(sda));
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_ev = scl & scl_d & sda_d & ~sda;
    wire stop_ev  = scl & scl_d & ~sda_d & sda;

    // ------------------------------------------------
    // own address
    // ------------------------------------------------
    logic [4:0] low_addr;
    always_comb begin
        case ({strap_addr_pin_hi, strap_addr_pin_mid, strap_addr_pin_lo})
            {`TMS_STRAP_LO, `TMS_STRAP_NC, `TMS_STRAP_LO}: low_addr = 5'h00;
            {`TMS_STRAP_LO, `TMS_STRAP_HI, `TMS_STRAP_NC}: low_addr = 5'h01;
            {`TMS_STRAP_LO, `TMS_STRAP_NC, `TMS_STRAP_NC}: low_addr = 5'h02;
            {`TMS_STRAP_LO, `TMS_STRAP_NC, `TMS_STRAP_HI}: low_addr = 5'h03;
            {`TMS_STRAP_LO, `TMS_STRAP_LO, `TMS_STRAP_LO}: low_addr = 5'h04;
            {`TMS_STRAP_LO, `TMS_STRAP_HI, `TMS_STRAP_HI}: low_addr = 5'h05;
            {`TMS_STRAP_LO, `TMS_STRAP_LO, `TMS_STRAP_NC}: low_addr = 5'h06;
            {`TMS_STRAP_LO, `TMS_STRAP_LO, `TMS_STRAP_HI}: low_addr = 5'h07;
            {`TMS_STRAP_NC, `TMS_STRAP_NC, `TMS_STRAP_LO}: low_addr = 5'h08;
            {`TMS_STRAP_NC, `TMS_STRAP_HI, `TMS_STRAP_NC}: low_addr = 5'h09;
            {`TMS_STRAP_NC, `TMS_STRAP_NC, `TMS_STRAP_NC}: low_addr = 5'h0a;
            {`TMS_STRAP_NC, `TMS_STRAP_NC, `TMS_STRAP_HI}: low_addr = 5'h0b;
            {`TMS_STRAP_NC, `TMS_STRAP_LO, `TMS_STRAP_LO}: low_addr = 5'h0c;
            {`TMS_STRAP_NC, `TMS_STRAP_HI, `TMS_STRAP_HI}: low_addr = 5'h0d;
            {`TMS_STRAP_NC, `TMS_STRAP_LO, `TMS_STRAP_NC}: low_addr = 5'h0e;
            {`TMS_STRAP_NC, `TMS_STRAP_LO, `TMS_STRAP_HI}: low_addr = 5'h0f;
            {`TMS_STRAP_HI, `TMS_STRAP_NC, `TMS_STRAP_LO}: low_addr = 5'h10;
            {`TMS_STRAP_HI, `TMS_STRAP_HI, `TMS_STRAP_NC}: low_addr = 5'h11;
            {`TMS_STRAP_HI, `TMS_STRAP_NC, `TMS_STRAP_NC}: low_addr = 5'h12;
            {`TMS_STRAP_HI, `TMS_STRAP_NC, `TMS_STRAP_HI}: low_addr = 5'h13;
            {`TMS_STRAP_HI, `TMS_STRAP_LO, `TMS_STRAP_LO}: low_addr = 5'h14;
            {`TMS_STRAP_HI, `TMS_STRAP_HI, `TMS_STRAP_HI}: low_addr = 5'h15;
            {`TMS_STRAP_HI, `TMS_STRAP_LO, `TMS_STRAP_NC}: low_addr = 5'h16;
            {`TMS_STRAP_HI, `TMS_STRAP_LO, `TMS_STRAP_HI}: low_addr = 5'h17;
            {`TMS_STRAP_HI, `TMS_STRAP_HI, `TMS_STRAP_LO}: low_addr = 5'h18;
            {`TMS_STRAP_LO, `TMS_STRAP_HI, `TMS_STRAP_LO}: low_addr = 5'h19;
            {`TMS_STRAP_NC, `TMS_STRAP_HI, `TMS_STRAP_LO}: low_addr = 5'h1a;
            default:                                       low_addr = 5'h0a;
        endcase
    end
    wire [6:0] own_addr = {`TMS_ADDR_TOP, low_addr};

    // ------------------------------------------------
    // registers and aux pins
    // ------------------------------------------------
    logic [7:0] reg2;
    logic [1:0] drv;
    localparam logic [7:0] REG1_RST = `TMS_REG1_RST;
    wire  [7:0] reg1 = {2'h0, drv, 2'h0, a1_q, a2_q};
    wire dir1 = reg2[`TMS_REG2_DIR1];
    wire dir2 = reg2[`TMS_REG2_DIR2];
    wire od1  = reg2[`TMS_REG2_OD1];
    wire od2  = reg2[`TMS_REG2_OD2];
    always_comb begin
        aux_pin_one_out = od1 ? 1'b0 : drv[1];
        aux_pin_one_oe  = dir1 & (od1 ? ~drv[1] : 1'b1);
        aux_pin_two_out = od2 ? 1'b0 : drv[0];
        aux_pin_two_oe  = dir2 & (od2 ? ~drv[0] : 1'b1);
    end

    // ------------------------------------------------
    // transaction engine
    // ------------------------------------------------
    tms_state_e st, next_st;
    logic [7:0] sh, next_sh;
    logic [3:0] bitn, next_bitn;
    logic [1:0] ptr, next_ptr;
    logic [7:0] wbuf, next_wbuf;
    logic       wpend, next_wpend;
    logic       oe, next_oe;
    logic       alert, next_alert;
    logic [7:0] rbyte, next_rbyte;
    tms_state_e after, next_after;
    logic [7:0] next_reg2, next_reg3, next_reg0w;
    logic [1:0] next_drv;
    logic       next_r0s;

    always_comb begin
        next_st = st; next_sh = sh; next_bitn = bitn; next_ptr = ptr;
        next_wbuf = wbuf; next_wpend = wpend; next_oe = oe;
        next_alert = alert | alert_set; next_rbyte = rbyte;
        next_after = after; next_reg2 = reg2; next_reg3 = reg3_ctrl; next_drv = drv;
        next_reg0w = reg0_wdata; next_r0s = 1'b0;
        if (start_ev) begin
            next_st = TMS_ADDR; next_bitn = 4'h0; next_oe = 1'b0;
            next_wpend = 1'b0;
        end else if (stop_ev) begin
            next_st = TMS_IDLE; next_oe = 1'b0; next_wpend = 1'b0;
            if (wpend) begin
                case (ptr)
                    2'h0: begin next_reg0w = wbuf; next_r0s = 1'b1; end
                    2'h1: next_drv = wbuf[`TMS_REG1_DRV1 -: 2];
                    2'h2: next_reg2 = wbuf;
                    default: next_reg3 = wbuf;
                endcase
            end
        end else if (scl_rise && (st == TMS_ADDR || st == TMS_CMD || st == TMS_DATA)) begin
            next_sh = {sh[6:0], sda}; next_bitn = bitn + 4'h1;
        end else if (scl_fall) begin
            case (st)
                TMS_ADDR, TMS_CMD, TMS_DATA: begin
                    if (bitn == 4'h8) begin
                        next_bitn = 4'h0; next_oe = 1'b0; next_after = TMS_SKIP;
                        if (st == TMS_ADDR) begin
                            if (sh[7:1] == own_addr) begin
                                next_oe = 1'b1; next_alert = alert_set;
                                next_after = sh[0] ? TMS_RDATA : TMS_CMD;
                                next_rbyte = (ptr == 2'h1) ? reg1 : (ptr == 2'h2) ? reg2 :
                                             (ptr == 2'h3) ? reg3_ctrl : 8'h00;
                            end else if (!sh[0] && sh[7:1] == `TMS_BCAST_ADDR
                                         && reg2[`TMS_REG2_BCAST]) begin
                                next_oe = 1'b1; next_after = TMS_CMD;
                            end else if (sh[0] && sh[7:1] == `TMS_ARA_ADDR && alert) begin
                                next_oe = 1'b1; next_after = TMS_RDATA;
                                next_rbyte = {own_addr, 1'b1}; next_alert = alert_set;
                            end
                        end else if (st == TMS_CMD) begin
                            next_oe = 1'b1; next_after = TMS_DATA; next_ptr = sh[1:0];
                        end else begin
                            next_oe = 1'b1; next_after = TMS_SKIP; next_wbuf = sh; next_wpend = 1'b1;
                        end
                        next_st = TMS_ACK;
                    end
                end
                TMS_ACK: begin
                    next_oe = 1'b0; next_st = after; next_sh = 8'h00;
                    if (after == TMS_RDATA) begin
                        next_oe = ~rbyte[7]; next_sh = {rbyte[6:0], 1'b0};
                    end
                end
                TMS_RDATA: begin
                    next_bitn = bitn + 4'h1;
                    if (bitn == 4'h7) begin
                        next_oe = 1'b0; next_st = TMS_RACK; next_bitn = 4'h0;
                    end else begin
                        next_oe = ~sh[7]; next_sh = {sh[6:0], 1'b0};
                    end
                end
                TMS_RACK: next_st = TMS_SKIP;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= TMS_IDLE; sh <= 8'h00; bitn <= 4'h0; ptr <= 2'h0; wbuf <= 8'h00;
            wpend <= 1'b0; oe <= 1'b0; alert <= 1'b0; rbyte <= 8'h00;
            after <= TMS_IDLE; reg2 <= `TMS_REG2_RST; reg3_ctrl <= 8'h00;
            drv <= REG1_RST[`TMS_REG1_DRV1 -: 2]; reg0_wdata <= 8'h00; reg0_wstrobe <= 1'b0;
            scl_d <= 1'b1; sda_d <= 1'b1;
            a1_s <= 1'b0; a1_q <= 1'b0; a2_s <= 1'b0; a2_q <= 1'b0;
        end else begin
            st <= next_st; sh <= next_sh; bitn <= next_bitn; ptr <= next_ptr; wbuf <= next_wbuf;
            wpend <= next_wpend; oe <= next_oe; alert <= next_alert;
            rbyte <= next_rbyte; after <= next_after; reg2 <= next_reg2;
            reg3_ctrl <= next_reg3; drv <= next_drv; reg0_wdata <= next_reg0w;
            reg0_wstrobe <= next_r0s; scl_d <= scl; sda_d <= sda;
            a1_s <= aux_pin_one_in; a1_q <= a1_s; a2_s <= aux_pin_two_in; a2_q <= a2_s;
        end
    end
    assign data_oe      = oe;
    assign alert_active = alert;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence stop_s; stop_ev && wpend; endsequence
    sequence addr_done_s; scl_fall && st == TMS_ADDR && bitn == 4'h8; endsequence
    commit_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(reg2) |-> $past(stop_ev) && $past(wpend) && $past(ptr) == 2'h2)
        else $error("register two changed outside a stop commit");
    rstart_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        start_ev |=> !wpend) else $error("write survived repeated start");
    input_undriven_a: assert property (@(posedge clk) disable iff (sys_rst)
        !dir1 |-> !aux_pin_one_oe) else $error("input pin driven");
    od_low_only_a: assert property (@(posedge clk) disable iff (sys_rst)
        aux_pin_one_oe && od1 |-> !aux_pin_one_out) else $error("open drain drove high");
    strobe_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        stop_s ##0 (ptr == 2'h0) |=> reg0_wstrobe && reg0_wdata == $past(wbuf))
        else $error("pointer zero commit lost");
    addr_top_a: assert property (@(posedge clk) own_addr[6:5] == `TMS_ADDR_TOP)
        else $error("address top bits wrong");
    bcast_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        addr_done_s ##0 (sh == {`TMS_BCAST_ADDR, 1'b0} && !reg2[`TMS_REG2_BCAST]) |=> !oe)
        else $error("masked broadcast write acknowledged");
    sense_track_a: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst, 2) |-> reg1[`TMS_REG1_SNS1] == $past(aux_pin_one_in, 2))
        else $error("sensed level stale");
    drive_echo_a: assert property (@(posedge clk) disable iff (sys_rst)
        aux_pin_two_oe && !od2 |-> aux_pin_two_out == reg1[`TMS_REG1_DRV2])
        else $error("driven level not reported");
endmodule

// ### dv/tms_master.sv
// upstream two-wire bus master model
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module tms_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_in
);
    // --------------------------------
    // steps of 64 ns, 224 ns per bit
    // --------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b0;
        #64 scl = 1'b1;
        #64 sda_low = 1'b1;
        #64 scl = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #64 scl = 1'b1;
        #64 sda_low = 1'b0;
        #64;
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low = !b;
        #64 scl = 1'b1;
        #64 r = sda_in;
        #64 scl = 1'b0;
        #32;
    endtask
    // byte out, msb first, ack taken from slave
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    // byte in, master answers not-ack
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(1'b1, d[i]);
        xbit(1'b1, r);
    endtask
    // clock pulse shorter than the filter span
    task automatic glitch();
        scl = 1'b1;
        #45 scl = 1'b0;
        #64;
    endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the two-wire slave port and aux pins
// assumes tms_master drives the upstream wires; pull-ups on data and aux pins
`timescale 1ns/1ps
module tb_top;
    import tms_pkg::*;
    logic       clk, sys_rst, scl, m_sda_low, sda_w, data_oe;
    tms_strap_t s_lo, s_mid, s_hi;
    logic       alert_set, alert_active, hold1, reg0_wstrobe, strobe_seen;
    logic       p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe;
    logic [7:0] reg0_wdata, reg3_ctrl, strobe_data, own, d;
    logic       ok, k1, k2, k3;
    int         bad_count, n_tests;
    assign sda_w = !(m_sda_low | data_oe);
    assign p1_in = hold1 ? 1'b0 : (p1_oe ? p1_out : 1'b1);
    assign p2_in = p2_oe ? p2_out : 1'b1;
    tms_master m_u (.scl(scl), .sda_low(m_sda_low), .sda_in(sda_w));
    tms_slave dut_u (.clk(clk), .sys_rst(sys_rst), .strap_addr_pin_lo(s_lo), .strap_addr_pin_mid(s_mid),
        .strap_addr_pin_hi(s_hi), .upstream_clock_line(scl), .upstream_data_line(sda_w), .data_oe(data_oe),
        .alert_set(alert_set), .alert_active(alert_active), .aux_pin_one_in(p1_in), .aux_pin_one_out(p1_out),
        .aux_pin_one_oe(p1_oe), .aux_pin_two_in(p2_in), .aux_pin_two_out(p2_out), .aux_pin_two_oe(p2_oe),
        .reg0_wdata(reg0_wdata), .reg0_wstrobe(reg0_wstrobe), .reg3_ctrl(reg3_ctrl));
    // --------------------------------
    // clock and strobe capture
    // --------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (reg0_wstrobe === 1'b1) begin
            strobe_seen <= 1'b1;
            strobe_data <= reg0_wdata;
        end
    end
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic settle();
        repeat (20) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] pins();
        return {4'h0, p1_oe, p1_oe & p1_out, p2_oe, p2_oe & p2_out};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] v);
        m_u.start();
        m_u.wbyte(a, k1);
        m_u.wbyte(c, k2);
        m_u.wbyte(v, k3);
        m_u.stop();
        settle();
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [7:0] a);
        m_u.start();
        m_u.wbyte(a, ok);
        m_u.rbyte(d);
        m_u.stop();
        settle();
    endtask
    task automatic pulse_alert();
        alert_set = 1'b1;
        @(posedge clk);
        #1 alert_set = 1'b0;
        settle();
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_addr();
        // {hi, mid, lo straps, address byte}
        logic [13:0] tbl [5] = '{14'h0880, 14'h2a94, 14'h24b4, 14'h15aa, 14'h0088};
        for (int i = 0; i < 5; i++) begin
            {s_hi, s_mid, s_lo} = tbl[i][13:8];
            own = tbl[i][7:0];
            settle();
            wr(own, 8'h03, 8'h40 + 8'(i));
            chk("own ack", 8'h01, {7'h0, ok});
            chk("own data", 8'h40 + 8'(i), reg3_ctrl);
            wr(own ^ 8'h40, 8'h03, 8'h00);
            chk("top bits ack", 8'h00, {7'h0, ok});
            wr(own ^ 8'h04, 8'h03, 8'h00);
            chk("near ack", 8'h00, {7'h0, ok});
        end
    endtask
    task automatic t_bcast();
        wr(8'hba, 8'h03, 8'h5b);
        chk("bcast", 8'h5b, ok ? reg3_ctrl : 8'hff);
        wr(own, 8'h02, 8'h00);
        wr(8'hba, 8'h03, 8'h66);
        chk("masked ack", 8'h00, {7'h0, ok});
        chk("masked data", 8'h5b, reg3_ctrl);
        wr(own, 8'h02, 8'h80);
    endtask
    task automatic t_commit();
        wr(own, 8'h03, 8'h11);
        strobe_seen = 1'b0;
        m_u.start();
        m_u.wbyte(own, k1);
        m_u.wbyte(8'h00, k1);
        m_u.wbyte(8'h5a, k1);
        settle();
        chk("no early commit", 8'h00, {7'h0, strobe_seen});
        m_u.stop();
        settle();
        chk("commit at stop", 8'h5a, strobe_seen ? strobe_data : 8'hff);
        m_u.start();
        m_u.wbyte(own, k1);
        m_u.wbyte(8'h03, k1);
        m_u.wbyte(8'h22, k1);
        rd(own | 8'h01);
        chk("restart discard", 8'h11, reg3_ctrl);
    endtask
    task automatic t_gpio();
        hold1 = 1'b1;
        wr(own, 8'h01, 8'h30);
        chk("inputs", 8'h00, pins());
        rd(own | 8'h01);
        chk("sense in", 8'h31, d & 8'h33);
        wr(own, 8'h02, 8'hf0);
        rd(own | 8'h01);
        chk("mode read", 8'hf0, d);
        wr(own, 8'h01, 8'h30);
        chk("drive high", 8'h03, pins());
        rd(own | 8'h01);
        chk("held low", 8'h31, d & 8'h33);
        hold1 = 1'b0;
        wr(own, 8'h01, 8'h00);
        chk("drive low", 8'h0a, pins());
        rd(own | 8'h01);
        chk("sense low", 8'h00, d & 8'h33);
        wr(own, 8'h02, 8'h80);
    endtask
    task automatic t_alert();
        rd(8'h19);
        chk("ara idle", 8'h00, {7'h0, ok});
        pulse_alert();
        chk("alert on", 8'h01, {7'h0, alert_active});
        rd(8'h19);
        chk("ara ack", 8'h01, {7'h0, ok});
        chk("ara addr", {1'b0, own[7:1]}, {1'b0, d[7:1]});
        chk("ara release", 8'h00, {7'h0, alert_active});
        pulse_alert();
        wr(own, 8'h03, 8'h77);
        chk("own release", 8'h00, {7'h0, alert_active});
    endtask
    task automatic t_glitch();
        m_u.start();
        m_u.wbyte(own, k1);
        m_u.wbyte(8'h03, k2);
        m_u.glitch();
        m_u.wbyte(8'hc3, k3);
        m_u.stop();
        settle();
        chk("glitch", 8'hc3, (k1 & k2 & k3) ? reg3_ctrl : 8'hff);
    endtask
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        {s_hi, s_mid, s_lo} = 6'h2a;
        own = 8'h94;
        alert_set = 1'b0;
        hold1 = 1'b0;
        bad_count = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        settle();
        t_addr();
        t_bcast();
        t_commit();
        t_gpio();
        t_alert();
        t_glitch();
        end_sim();
    end
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
endmodule
